// ===== src/serial_bcd_timekeeper.sv
// serial_bcd_timekeeper: three-wire serial clock/calendar, eight bcd registers.
// assumes the pins are asynchronous to clk_sys_in; osc_tick_in is a one-cycle
// strobe on clk_sys_in at 32768 Hz from the oscillator domain logic.
//
// Contract
// - eight readable writable packed bcd registers
// - every transfer opens with command byte
// - command bit0 zero writes, one reads
// - command bits 3..1 select register index
// - single commands are 1000, index, direction
// - 10111110 burst write, 10111111 burst read
// - burst starts register zero, ascending order
// - writes ignored while write lock set; single writes to lock still land
// - lock bit seven, burst cannot alter
// - seconds bit seven halts timekeeping
// - writing halt zero resumes timekeeping
// - hours bit seven selects 12-hour format
// - 12-hour bit five is meridiem flag
// - 24-hour bit five is twenty-hour digit
// - fields keep bcd ranges, lock low zero
// - sample on rising, drive after falling, lsb
// - select low aborts, releases data line
// - single write takes eight bits only
`timescale 1ns/1ns
`default_nettype none

module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic             clk_sys_in,
   input  wire logic             rst_in,
   input  wire logic             flush_in,    // drop everything
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic      [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];   // storage array
   logic [AW-1:0]    wr_ptr_r;      // write pointer
   logic [AW-1:0]    rd_ptr_r;      // read pointer
   logic [AW:0]      count_r;       // occupancy
   logic             push;
   logic             pop;
   assign in_ready_out  = (count_r != (AW+1)'(DEPTH));
   assign out_valid_out = (count_r != '0);
   assign out_data_out  = mem[rd_ptr_r];
   assign push = in_valid_in && in_ready_out;
   assign pop  = out_valid_out && out_ready_in;
   // storage writes, no reset needed
   always_ff @(posedge clk_sys_in) begin
      if (push) begin
         mem[wr_ptr_r] <= in_data_in;
      end
   end
   // pointers and count
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else if (flush_in) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
         end
         count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

module serial_bcd_timekeeper
   import timekeeper_pkg::*;
#(
   parameter int FIFO_DEPTH = 32
) (
   input  wire logic clk_sys_in,
   input  wire logic rst_in,
   input  wire logic osc_tick_in,          // 32768 Hz strobe
   input  wire logic transfer_select_in,   // high frames a transfer
   input  wire logic shift_clk_in,         // host shift clock
   input  wire logic data_in,              // data pin input
   output logic      data_out,             // data pin output
   output logic      data_oe_out           // high while driving data pin
);
   // bcd increment with wrap from hi to lo
   function automatic logic [7:0] bcd_inc(input logic [7:0] v,
                                          input logic [7:0] hi,
                                          input logic [7:0] lo);
      logic [7:0] r;
      r = v;
      if (v >= hi) r = lo;
      else if (v[3:0] == 4'h9) r = {v[7:4] + 4'h1, 4'h0};
      else r = {v[7:4], v[3:0] + 4'h1};
      return r;
   endfunction

   // last day of bcd month, leap from two-digit bcd year
   function automatic logic [7:0] month_days(input logic [7:0] mon,
                                             input logic [7:0] yr);
      logic [7:0] d;
      logic       leap;
      leap = ((yr[4] == 1'b0) && (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 ||
              yr[3:0] == 4'h8)) ||
             ((yr[4] == 1'b1) && (yr[3:0] == 4'h2 || yr[3:0] == 4'h6));
      case (mon)
         8'h02:   d = leap ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: d = 8'h30;
         default: d = 8'h31;
      endcase
      return d;
   endfunction

   // three-stage pin synchronisers
   logic [2:0] sel_sync_r;
   logic [2:0] sck_sync_r;
   logic [2:0] dat_sync_r;
   logic       sel_q_r;     // filtered select
   logic       sck_q_r;     // filtered shift clock
   logic       dat_q;       // stage-three data level, not filtered
   logic       sck_rise;
   logic       sck_fall;

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         sel_sync_r <= '0;
         sck_sync_r <= '0;
         dat_sync_r <= '0;
      end else begin
         sel_sync_r <= {sel_sync_r[1:0], transfer_select_in};
         sck_sync_r <= {sck_sync_r[1:0], shift_clk_in};
         dat_sync_r <= {dat_sync_r[1:0], data_in};
      end
   end
   // a change counts only when stages two and three agree
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         sel_q_r <= 1'b0;
         sck_q_r <= 1'b0;
      end else begin
         if (sel_sync_r[1] == sel_sync_r[2]) sel_q_r <= sel_sync_r[2];
         if (sck_sync_r[1] == sck_sync_r[2]) sck_q_r <= sck_sync_r[2];
      end
   end
   // data is stable around rising edges, stage three suffices
   assign dat_q    = dat_sync_r[2];
   assign sck_rise = sel_q_r && !sck_q_r && (sck_sync_r[1] && sck_sync_r[2]);
   assign sck_fall = sel_q_r && sck_q_r && !(sck_sync_r[1] || sck_sync_r[2]);

   typedef enum {ST_IDLE, ST_CMD, ST_WRITE, ST_READ, ST_DONE} link_state_t;
   link_state_t state_r;
   logic [7:0]  regs_r [NUM_REGS];   // clock/calendar array
   logic [7:0]  shift_r;             // command / data shifter
   logic [2:0]  bit_cnt_r;           // bit within byte
   logic [2:0]  idx_r;               // current register index
   logic        burst_r;             // burst transfer
   logic [7:0]  snap_r;              // read snapshot
   logic [15:0] osc_cnt_r;           // oscillator divider
   logic        sec_pulse;
   logic        halted;
   logic [7:0]  wr_byte;             // byte assembled this edge
   logic        wr_done;             // full byte arrived
   // fifo connection for incoming write bytes
   logic        fifo_in_ready;
   logic        fifo_out_valid;
   logic [10:0] fifo_out_data;       // {index, byte}
   logic        fifo_pop;
   logic        fifo_push;

   assign halted  = regs_r[IDX_SEC][BIT_HALT];
   assign wr_byte = {dat_q, shift_r[7:1]};
   assign wr_done = sck_rise && (bit_cnt_r == 3'(BYTE_BITS-1));

   // oscillator divider, held at zero while halted
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         osc_cnt_r <= '0;
      end else if (halted) begin
         osc_cnt_r <= '0;
      end else if (osc_tick_in) begin
         osc_cnt_r <= (osc_cnt_r == 16'(OSC_DIV-1)) ? '0 : osc_cnt_r + 16'h1;
      end
   end
   assign sec_pulse = osc_tick_in && !halted && (osc_cnt_r == 16'(OSC_DIV-1));

   // serial link state machine
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         state_r   <= ST_IDLE;
         shift_r   <= RESET_BYTE;
         bit_cnt_r <= '0;
         idx_r     <= '0;
         burst_r   <= 1'b0;
      end else if (!sel_q_r) begin
         state_r   <= ST_IDLE;
         bit_cnt_r <= '0;
         burst_r   <= 1'b0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               state_r   <= ST_CMD;
               bit_cnt_r <= '0;
            end
            ST_CMD: if (sck_rise) begin
               shift_r   <= wr_byte;
               bit_cnt_r <= bit_cnt_r + 3'h1;
               if (wr_done) begin
                  bit_cnt_r <= '0;
                  if (wr_byte[7:1] == CMD_BURST_TOP) begin
                     burst_r <= 1'b1;
                     idx_r   <= IDX_SEC;
                     state_r <= wr_byte[0] ? ST_READ : ST_WRITE;
                  end else if (wr_byte[7:4] == CMD_SINGLE_TOP) begin
                     idx_r   <= wr_byte[3:1];
                     state_r <= wr_byte[0] ? ST_READ : ST_WRITE;
                  end else begin
                     state_r <= ST_DONE;  // test or unknown codes do nothing
                  end
               end
            end
            ST_WRITE: if (sck_rise) begin
               shift_r   <= wr_byte;
               bit_cnt_r <= bit_cnt_r + 3'h1;
               if (wr_done) begin
                  if (!burst_r || idx_r == IDX_LOCK) state_r <= ST_DONE;
                  else idx_r <= idx_r + 3'h1;
               end
            end
            ST_READ: if (sck_fall) begin
               bit_cnt_r <= bit_cnt_r + 3'h1;
               if (bit_cnt_r == 3'(BYTE_BITS-1) && burst_r) begin
                  idx_r <= idx_r + 3'h1;
               end
            end
            ST_DONE: state_r <= ST_DONE;  // extra clocks ignored
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // write bytes queue in the fifo; the array drains it between ticks
   // a full fifo cannot occur at one byte per eight shift clocks, but never overrun it
   assign fifo_push = (state_r == ST_WRITE) && wr_done && fifo_in_ready;
   assign fifo_pop  = fifo_out_valid && !sec_pulse;

   byte_fifo #(.WIDTH(11), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
      .clk_sys_in    (clk_sys_in),
      .rst_in        (rst_in),
      .flush_in      (1'b0),
      .in_valid_in   (fifo_push),
      .in_ready_out  (fifo_in_ready),
      .in_data_in    ({idx_r, wr_byte}),
      .out_valid_out (fifo_out_valid),
      .out_ready_in  (!sec_pulse),
      .out_data_out  (fifo_out_data)
   );

   // register array: host writes and timekeeping
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         for (int i = 0; i < NUM_REGS; i++) regs_r[i] <= RESET_BYTE;
      end else if (fifo_pop) begin
         if (fifo_out_data[10:8] == IDX_LOCK) begin
            if (!burst_r) begin
               regs_r[IDX_LOCK] <= fifo_out_data[7:0] & LOCK_MASK;
            end
         end else if (!regs_r[IDX_LOCK][BIT_LOCK]) begin
            regs_r[fifo_out_data[10:8]] <= fifo_out_data[7:0];
         end
      end else if (sec_pulse) begin
         logic [7:0] s;
         logic [7:0] m;
         logic [7:0] h;
         logic [7:0] hn;                                       // 12-hour count plus one
         s = bcd_inc(regs_r[IDX_SEC] & 8'h7F, 8'h59, 8'h00);
         regs_r[IDX_SEC] <= s;
         if (s == 8'h00) begin
            m = bcd_inc(regs_r[IDX_MIN], 8'h59, 8'h00);
            regs_r[IDX_MIN] <= m;
            if (m == 8'h00) begin
               h = regs_r[IDX_HOUR];
               // a call result cannot be part-selected, so it lands in hn first
               hn = bcd_inc({3'h0, h[4:0]}, 8'h12, 8'h01);
               if (h[BIT_H12]) begin
                  if (h[4:0] == 5'h11) begin
                     regs_r[IDX_HOUR] <= {h[7:6], ~h[BIT_MER], 5'h12};
                  end else begin
                     regs_r[IDX_HOUR] <= {h[7:5], hn[4:0]};
                  end
               end
               if (!h[BIT_H12] || h[4:0] == 5'h11) begin
                  if (!h[BIT_H12]) begin
                     regs_r[IDX_HOUR] <= bcd_inc(h & 8'h3F, 8'h23, 8'h00);
                  end
                  if (!h[BIT_H12] ? (h[5:0] == 6'h23) : h[BIT_MER]) begin
                     regs_r[IDX_WDAY] <= bcd_inc(regs_r[IDX_WDAY], 8'h07, 8'h01);
                     if (regs_r[IDX_DATE] >= month_days(regs_r[IDX_MON],
                                                        regs_r[IDX_YEAR])) begin
                        regs_r[IDX_DATE] <= 8'h01;
                        regs_r[IDX_MON]  <= bcd_inc(regs_r[IDX_MON], 8'h12, 8'h01);
                        if (regs_r[IDX_MON] == 8'h12) begin
                           regs_r[IDX_YEAR] <= bcd_inc(regs_r[IDX_YEAR], 8'h99, 8'h00);
                        end
                     end else begin
                        regs_r[IDX_DATE] <= bcd_inc(regs_r[IDX_DATE], 8'h31, 8'h01);
                     end
                  end
               end
            end
         end
      end
   end

   // read snapshot taken as each data byte starts
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         snap_r <= RESET_BYTE;
      end else if (state_r == ST_CMD && wr_done) begin
         snap_r <= regs_r[(wr_byte[7:1] == CMD_BURST_TOP) ? IDX_SEC : wr_byte[3:1]];
      end else if (state_r == ST_READ && sck_fall) begin
         if (bit_cnt_r == 3'(BYTE_BITS-1)) begin
            snap_r <= regs_r[burst_r ? idx_r + 3'h1 : idx_r];
         end else begin
            snap_r <= {1'b0, snap_r[7:1]};
         end
      end
   end

   // pin drive: first bit after first falling edge, lsb first
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         data_out    <= 1'b0;
         data_oe_out <= 1'b0;
      end else if (!sel_q_r || state_r != ST_READ) begin
         data_out    <= 1'b0;
         data_oe_out <= 1'b0;
      end else if (sck_fall) begin
         data_out    <= snap_r[0];
         data_oe_out <= 1'b1;
      end
   end
endmodule

`default_nettype wire

// ===== src/timekeeper_pkg.sv
// timekeeper_pkg: register indices, command codes, field positions, timing.
// assumes a 100 MHz system clock and a 32768 Hz oscillator tick input.
package timekeeper_pkg;
   localparam logic [2:0] IDX_SEC   = 3'h0;  // seconds_count
   localparam logic [2:0] IDX_MIN   = 3'h1;  // minutes_count
   localparam logic [2:0] IDX_HOUR  = 3'h2;  // hours_count
   localparam logic [2:0] IDX_DATE  = 3'h3;  // day_of_month
   localparam logic [2:0] IDX_MON   = 3'h4;  // month_count
   localparam logic [2:0] IDX_WDAY  = 3'h5;  // weekday_count
   localparam logic [2:0] IDX_YEAR  = 3'h6;  // year_count
   localparam logic [2:0] IDX_LOCK  = 3'h7;  // write_lock_reg
   localparam logic [3:0] CMD_SINGLE_TOP = 4'h8;  // 1000 in bits 7..4
   localparam logic [6:0] CMD_BURST_TOP  = 7'h5F; // 1011111 in bits 7..1
   localparam int BIT_HALT   = 7;    // oscillator_halt in seconds
   localparam int BIT_LOCK   = 7;    // write lock in write_lock_reg
   localparam int BIT_H12    = 7;    // hour format select
   localparam int BIT_MER    = 5;    // meridiem_flag / 20-hour bit
   localparam int OSC_DIV    = 32768; // oscillator cycles per second
   localparam int BYTE_BITS  = 8;
   localparam int NUM_REGS   = 8;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] LOCK_MASK  = 8'h80;
endpackage

// ===== tb/serial_host_model.sv
// serial_host_model: host side of the three-wire link, one framed transfer per call.
// assumes clk_sys_in at 10 ns; shift clock stands low outside frames.
`timescale 1ns/1ns
`default_nettype none

module serial_host_model (
   input  wire logic clk_sys_in,
   output logic      transfer_select_out,
   output logic      shift_clk_out,
   output logic      host_data_out,
   input  wire logic dev_data_in,
   input  wire logic dev_oe_in
);
   // 80 ns period: each half spans four system clocks, enough for the synchroniser
   localparam int HALF_NS = 40;

   // idle link at time zero
   initial begin
      transfer_select_out = 1'b0;
      shift_clk_out       = 1'b0;
      host_data_out       = 1'b0;
   end

   // framed transfer: command lsb first, then write or read bits
   task automatic xfer(input logic [7:0] cmd, input int nbits, input logic [63:0] wr,
                       output logic [63:0] rd);
      rd = '0;
      @(posedge clk_sys_in);
      #1;
      transfer_select_out = 1'b1;
      #(HALF_NS);
      for (int i = 0; i < nbits; i++) begin
         shift_clk_out = 1'b0;
         // host bits change while the clock is low, lsb first
         if (i < 8) begin
            host_data_out = cmd[i];
         end else if (!cmd[0]) begin
            host_data_out = wr[i-8];
         end else begin
            host_data_out = ~host_data_out; // released: never a stale level
         end
         #(HALF_NS);
         // sample device bit just before the rising edge
         if (i >= 8 && cmd[0]) begin
            rd[i-8] = dev_oe_in ? dev_data_in : 1'bx;
         end
         shift_clk_out = 1'b1;
         #(HALF_NS);
      end
      shift_clk_out = 1'b0;
      #(HALF_NS);
      transfer_select_out = 1'b0;
      host_data_out = ~host_data_out;
      // gap between frames well above four system clocks
      #(2 * HALF_NS);
   endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
// tb: self-checking bench for serial_bcd_timekeeper through the host model.
// assumes timekeeper_pkg and the design are compiled first.
`timescale 1ns/1ns
`default_nettype none

module tb
   import timekeeper_pkg::*;
;
   logic        clk_sys_in;  // system clock
   logic        rst;         // async reset
   logic        osc_tick;    // oscillator strobe
   logic        sel;         // transfer select pin
   logic        sclk;        // shift clock pin
   logic        hdata;       // host data bit
   logic        dout;        // device data bit
   logic        doe;         // device drives pin
   logic [63:0] rd;          // last read bits
   int          mismatches;
   int          n_tests;
   int          cycles;
   // register rows: written value and value read back
   logic [7:0]  row_wr  [8] = '{8'h59, 8'h45, 8'h92, 8'h31, 8'h12, 8'h07, 8'h99, 8'hFF};
   logic [7:0]  row_exp [8] = '{8'h59, 8'h45, 8'h92, 8'h31, 8'h12, 8'h07, 8'h99, 8'h80};

   serial_bcd_timekeeper serial_bcd_timekeeper_inst (
      .clk_sys_in         (clk_sys_in),
      .rst_in             (rst),
      .osc_tick_in        (osc_tick),
      .transfer_select_in (sel),
      .shift_clk_in       (sclk),
      .data_in            (hdata),
      .data_out           (dout),
      .data_oe_out        (doe)
   );

   serial_host_model serial_host_model_inst (
      .clk_sys_in          (clk_sys_in),
      .transfer_select_out (sel),
      .shift_clk_out       (sclk),
      .host_data_out       (hdata),
      .dev_data_in         (dout),
      .dev_oe_in           (doe)
   );

   // 100 MHz system clock
   initial begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end

   // hang guard: run needs about 72k cycles, two seconds of strobes dominate
   always @(posedge clk_sys_in) begin
      cycles++;
      if (cycles == 90000) begin
         mismatches++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // single-byte helpers, sixteen shift clocks each
   task automatic wr1(input logic [2:0] idx, input logic [7:0] val);
      serial_host_model_inst.xfer({CMD_SINGLE_TOP, idx, 1'b0}, 16, {56'h0, val}, rd);
   endtask

   task automatic rd1(input logic [2:0] idx);
      serial_host_model_inst.xfer({CMD_SINGLE_TOP, idx, 1'b1}, 16, 64'h0, rd);
   endtask

   // exactly one second of oscillator strobes, one per cycle
   task automatic tick_sec();
      @(posedge clk_sys_in);
      #1;
      osc_tick = 1'b1;
      repeat (OSC_DIV) @(posedge clk_sys_in);
      #1;
      osc_tick = 1'b0;
   endtask

   initial begin
      rst        = 1'b1;
      osc_tick   = 1'b0;
      mismatches = 0;
      n_tests    = 0;
      cycles     = 0;
      repeat (2) @(posedge clk_sys_in);
      #1;
      rst = 1'b0;
      repeat (3) @(posedge clk_sys_in);
      // every register written and read back; lock row last
      for (int i = 0; i < NUM_REGS; i++) begin
         wr1(i[2:0], row_wr[i]);
         rd1(i[2:0]);
         check(rd, {56'h0, row_exp[i]});
      end
      // locked: seconds write ignored, lock reg still writable
      wr1(IDX_SEC, 8'h11);
      rd1(IDX_SEC);
      check(rd, 64'h59);
      wr1(IDX_LOCK, 8'h00);
      rd1(IDX_LOCK);
      check(rd, 64'h00);
      // extra clocks after write ignored; single read repeats
      serial_host_model_inst.xfer({CMD_SINGLE_TOP, IDX_MIN, 1'b0}, 32, 64'h3412, rd);
      serial_host_model_inst.xfer({CMD_SINGLE_TOP, IDX_MIN, 1'b1}, 32, 64'h0, rd);
      check(rd, 64'h121212);
      // half-finished write and read cut off by select
      serial_host_model_inst.xfer({CMD_SINGLE_TOP, IDX_MIN, 1'b0}, 12, 64'h5, rd);
      serial_host_model_inst.xfer({CMD_SINGLE_TOP, IDX_MIN, 1'b1}, 12, 64'h0, rd);
      check({63'h0, doe}, 64'h0);
      rd1(IDX_MIN);
      check(rd, 64'h12);
      // halted oscillator keeps seconds still
      wr1(IDX_SEC, 8'h80);
      tick_sec();
      rd1(IDX_SEC);
      check(rd, 64'h80);
      // burst load clears halt; lock byte must not land
      serial_host_model_inst.xfer({CMD_BURST_TOP, 1'b0}, 72, 64'h8000030228235959, rd);
      serial_host_model_inst.xfer({CMD_BURST_TOP, 1'b1}, 72, 64'h0, rd);
      check(rd, 64'h0000030228235959);
      // 23:59:59 on 28 Feb of a leap year rolls to 29 Feb
      tick_sec();
      serial_host_model_inst.xfer({CMD_BURST_TOP, 1'b1}, 72, 64'h0, rd);
      check(rd, 64'h0000040229000000);
      print_verdict();
   end
endmodule
`default_nettype wire

// ===== tb/tk_checker_assertions.sv
// tk_checker: port-level checks of the serial timekeeper data pin.
// assumes pins move just after clk_sys_in edges; bound to the top module.
`timescale 1ns/1ns
`default_nettype none

module tk_checker (
   input  wire logic clk_sys_in,
   input  wire logic rst_in,
   input  wire logic osc_tick_in,
   input  wire logic transfer_select_in,
   input  wire logic shift_clk_in,
   input  wire logic data_in,
   input  wire logic data_out,
   input  wire logic data_oe_out
);
   // one domain, so clock and reset are stated once
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);

   // pin must be quiet on the first edge after reset
   AST_RESET_QUIET: assert property ($fell(rst_in) |-> !data_oe_out && !data_out)
      else $error("data pin active right after reset");
   // output bits only move after the shift clock was seen low
   AST_DATA_MOVES_LOW: assert property ($changed(data_out) |-> !$past(shift_clk_in))
      else $error("data pin changed while shift clock high");
   // driving starts only after a falling shift clock edge
   AST_OE_AFTER_FALL: assert property ($rose(data_oe_out) |-> !$past(shift_clk_in, 2))
      else $error("data pin driven without a falling edge");
   // a command must have been framed before any driving
   AST_OE_NEEDS_FRAME: assert property ($rose(data_oe_out) |-> $past(transfer_select_in, 8))
      else $error("data pin driven without a framed command");
   // dropping select frees the pin within the synchroniser delay
   AST_ABORT_RELEASE: assert property ($fell(transfer_select_in) |-> ##[1:8] !data_oe_out)
      else $error("data pin held after select low");
   // long idle means the pin stays released
   AST_IDLE_RELEASED: assert property (!transfer_select_in [*8] |-> !data_oe_out)
      else $error("data pin driven while idle");
   // undriven pin shows a settled low output
   AST_UNDRIVEN_LOW: assert property (!data_oe_out && !$past(data_oe_out) |-> !data_out)
      else $error("data output high while released");
   // release has select low as its cause
   AST_OE_FALL_CAUSE: assert property ($fell(data_oe_out) |-> !$past(transfer_select_in, 2))
      else $error("data pin released with select high");

   // main scenarios reached
   cover property ($rose(data_oe_out));
   cover property ($fell(transfer_select_in) && data_oe_out);
   cover property ($rose(shift_clk_in) && transfer_select_in);
endmodule

bind serial_bcd_timekeeper tk_checker tk_checker_inst (
   .clk_sys_in         (clk_sys_in),
   .rst_in             (rst_in),
   .osc_tick_in        (osc_tick_in),
   .transfer_select_in (transfer_select_in),
   .shift_clk_in       (shift_clk_in),
   .data_in            (data_in),
   .data_out           (data_out),
   .data_oe_out        (data_oe_out)
);
`default_nettype wire
